// [src/sadc_defs.svh]
// Register map, field positions, reset values and timing counts of the scan converter control.
// Assumes a 100 MHz pclk; included by the design module and by the bench.
//
// Contract
// - Software selects 8-bit or 10-bit results
// - One of eight channels converted at once
// - Trigger: software, timer, or falling external edge
// - Sample and hold, then successive approximation
// - One channel takes at least 6.12 us
// - Sampling lasts at least 2.0 us
// - Stored result may raise interrupt request
// - Request can start intelligent transfer service
// - Single mode: start to end, then stop
// - Sequential mode: scan repeats without stopping
// - Pausing mode: pause per channel, wrap around
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// Byte offsets
`define SADC_OFF_CTRL 12'h000
`define SADC_OFF_STAT 12'h004
`define SADC_OFF_DATA 12'h008
`define SADC_OFF_IRQ_STAT 12'h00C
`define SADC_OFF_IRQ_EN 12'h010
`define SADC_OFF_IRQ_CLR 12'h014

// Control fields
`define SADC_CTRL_START 0
`define SADC_CTRL_RES10 1
`define SADC_CTRL_MODE_LO 2
`define SADC_CTRL_MODE_HI 3
`define SADC_CTRL_TRIG_LO 4
`define SADC_CTRL_TRIG_HI 5
`define SADC_CTRL_SCH_LO 8
`define SADC_CTRL_SCH_HI 10
`define SADC_CTRL_ECH_LO 12
`define SADC_CTRL_ECH_HI 14
`define SADC_CTRL_XFER_EN 16
`define SADC_CTRL_RESET 32'h0000_0000

// Interrupt status bits
`define SADC_IRQ_DONE 0
`define SADC_IRQ_SCAN 1

// Timing
`define SADC_CLK_MHZ 100
`define SADC_T_SAMPLE_NS 2000
`define SADC_T_CONV_NS 6120
`define SADC_SAMPLE_CYC ((`SADC_T_SAMPLE_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_CONV_CYC ((`SADC_T_CONV_NS * `SADC_CLK_MHZ + 999) / 1000)

`endif

// [src/sadc_pkg.sv]
// Types of the scan converter control.
// Assumes sadc_defs.svh is on the include path.
`default_nettype none
package sadc_pkg;
  typedef enum logic [1:0] {SADC_SINGLE, SADC_SEQUENTIAL, SADC_PAUSING, SADC_MODE_RSVD} sadc_mode_e;
  typedef enum logic [1:0] {SADC_TRIG_SW, SADC_TRIG_TIMER, SADC_TRIG_EXT, SADC_TRIG_RSVD} sadc_trig_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_APPROX, ST_STORE, ST_PAUSE} sadc_state_e;
  // Analog front end handshake
  typedef struct packed {
    logic sample;
    logic [2:0] chan;
    logic [9:0] dac_code;
  } sadc_afe_s;
endpackage
`default_nettype wire

// [src/sadc_ctrl.sv]
// Scan converter control: APB registers, trigger select, channel scan and SAR sequencer.
// Assumes the analog front end samples while afe.sample is high and returns
// a comparator level that is valid one pclk after dac_code changes.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "sadc_defs.svh"
`default_nettype none
module sadc_ctrl
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Triggers
  input wire logic timer_trig,
  input wire logic ext_trig,
  // Analog front end
  output sadc_afe_s afe,
  input wire logic comp_hi,
  // System
  output logic busy,
  output logic irq,
  output logic xfer_req
);

  localparam int SAMPLE_CYC = `SADC_SAMPLE_CYC;
  localparam int APPROX_CYC = `SADC_CONV_CYC - `SADC_SAMPLE_CYC;
  // Rounded up so a whole conversion never undercuts the minimum time
  localparam int BIT_CYC = (APPROX_CYC + 9) / 10;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic [31:0] ctrl_r;
  logic [9:0] data_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  sadc_state_e state_r;
  logic [2:0] chan_r;
  logic [9:0] code_r;
  logic [3:0] bit_r;
  logic [9:0] cnt_r;
  logic ext_d_r;
  logic xfer_r;

  wire logic wr = psel && penable && pwrite;
  wire logic rd_ok = hit(paddr, `SADC_OFF_CTRL) || hit(paddr, `SADC_OFF_STAT)
    || hit(paddr, `SADC_OFF_DATA) || hit(paddr, `SADC_OFF_IRQ_STAT)
    || hit(paddr, `SADC_OFF_IRQ_EN) || hit(paddr, `SADC_OFF_IRQ_CLR);

  wire logic res10 = ctrl_r[`SADC_CTRL_RES10];
  wire sadc_mode_e mode = sadc_mode_e'(ctrl_r[`SADC_CTRL_MODE_HI:`SADC_CTRL_MODE_LO]);
  wire sadc_trig_e tsel = sadc_trig_e'(ctrl_r[`SADC_CTRL_TRIG_HI:`SADC_CTRL_TRIG_LO]);
  wire logic [2:0] start_ch = ctrl_r[`SADC_CTRL_SCH_HI:`SADC_CTRL_SCH_LO];
  wire logic [2:0] end_ch = ctrl_r[`SADC_CTRL_ECH_HI:`SADC_CTRL_ECH_LO];

  // Software start pulse comes from a write of the start bit
  wire logic sw_start = wr && hit(paddr, `SADC_OFF_CTRL) && pwdata[`SADC_CTRL_START];
  wire logic ext_fall = ext_d_r && !ext_trig;
  logic trig;
  always_comb begin
    case (tsel)
      SADC_TRIG_SW: trig = sw_start;
      SADC_TRIG_TIMER: trig = timer_trig;
      SADC_TRIG_EXT: trig = ext_fall;
      default: trig = 1'b0;
    endcase
  end

  wire logic store = state_r == ST_STORE;
  wire logic at_end = chan_r == end_ch;
  // Mode 3 decodes as single, so it raises the scan flag as well
  wire logic scan_done = store && at_end && mode != SADC_SEQUENTIAL && mode != SADC_PAUSING;

  // APB: zero wait states, unmapped addresses raise pslverr
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SADC_CTRL_RESET;
    end else if (wr && hit(paddr, `SADC_OFF_CTRL)) begin
      ctrl_r <= pwdata & 32'h0001_773E;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 2'h0;
    end else if (wr && hit(paddr, `SADC_OFF_IRQ_EN)) begin
      irq_en_r <= pwdata[1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr && hit(paddr, `SADC_OFF_IRQ_CLR)) ? pwdata[1:0] : 2'h0))
        | {scan_done, store};
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (hit(paddr, `SADC_OFF_CTRL)) prdata = ctrl_r;
      else if (hit(paddr, `SADC_OFF_STAT)) prdata = {24'h00_0000, 1'b0, chan_r, 1'b0, 2'h0, busy};
      else if (hit(paddr, `SADC_OFF_DATA)) prdata = {22'h00_0000, data_r};
      else if (hit(paddr, `SADC_OFF_IRQ_STAT)) prdata = {30'h0000_0000, irq_stat_r};
      else if (hit(paddr, `SADC_OFF_IRQ_EN)) prdata = {30'h0000_0000, irq_en_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_r <= 1'b1;
    end else begin
      ext_d_r <= ext_trig;
    end
  end

  // Scan sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      chan_r <= 3'h0;
      cnt_r <= 10'h000;
      bit_r <= 4'h0;
      code_r <= 10'h000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig) begin
            state_r <= ST_SAMPLE;
            chan_r <= start_ch;
            cnt_r <= 10'(SAMPLE_CYC - 1);
          end
        end
        ST_SAMPLE: begin
          if (cnt_r == 10'h000) begin
            state_r <= ST_APPROX;
            bit_r <= 4'h9;
            code_r <= 10'h200;
            cnt_r <= 10'(BIT_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        ST_APPROX: begin
          if (cnt_r != 10'h000) begin
            cnt_r <= cnt_r - 10'h001;
          end else begin
            if (!comp_hi) code_r[bit_r] <= 1'b0;
            if (bit_r == 4'h0) begin
              state_r <= ST_STORE;
            end else begin
              code_r[bit_r - 4'h1] <= 1'b1;
              bit_r <= bit_r - 4'h1;
              cnt_r <= 10'(BIT_CYC - 1);
            end
          end
        end
        ST_STORE: begin
          chan_r <= at_end ? start_ch : chan_r + 3'h1;
          cnt_r <= 10'(SAMPLE_CYC - 1);
          case (mode)
            SADC_SEQUENTIAL: state_r <= ST_SAMPLE;
            SADC_PAUSING: state_r <= ST_PAUSE;
            default: state_r <= at_end ? ST_IDLE : ST_SAMPLE;
          endcase
        end
        ST_PAUSE: begin
          if (trig) state_r <= ST_SAMPLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign busy = state_r != ST_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 10'h000;
    end else if (store) begin
      data_r <= res10 ? code_r : {2'h0, code_r[9:2]};
    end
  end

  // Transfer request pulses once per stored result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_r <= 1'b0;
    end else begin
      xfer_r <= store && ctrl_r[`SADC_CTRL_XFER_EN];
    end
  end
  assign xfer_req = xfer_r;

  assign afe.sample = state_r == ST_SAMPLE;
  assign afe.chan = chan_r;
  assign afe.dac_code = code_r;

  // Phase run lengths, read only by the timing assertions below;
  // they saturate so a long run never wraps into a false short one
  logic [10:0] samp_run_r;
  logic [10:0] conv_run_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_run_r <= 11'h000;
    end else if (state_r != ST_SAMPLE) begin
      samp_run_r <= 11'h000;
    end else if (samp_run_r != 11'h7FF) begin
      samp_run_r <= samp_run_r + 11'h001;
    end
  end

  // Cleared outside sampling and approximation, so it spans one channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_run_r <= 11'h000;
    end else if (state_r != ST_SAMPLE && state_r != ST_APPROX) begin
      conv_run_r <= 11'h000;
    end else if (conv_run_r != 11'h7FF) begin
      conv_run_r <= conv_run_r + 11'h001;
    end
  end

  a_sample_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r == ST_SAMPLE) |-> (state_r == ST_SAMPLE) [*8])
    else $error("sampling phase too short");
  a_busy_trig: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && trig) |=> busy)
    else $error("trigger not accepted");
  a_store_irq: assert property (@(posedge pclk) disable iff (!presetn)
    store |=> irq_stat_r[`SADC_IRQ_DONE])
    else $error("done flag missing");
  a_store_xfer: assert property (@(posedge pclk) disable iff (!presetn)
    (store && ctrl_r[`SADC_CTRL_XFER_EN]) |=> xfer_req)
    else $error("transfer request missing");
  a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (store && at_end && mode == SADC_SINGLE) |=> !busy)
    else $error("single scan did not stop");
  a_seq_go: assert property (@(posedge pclk) disable iff (!presetn)
    (store && mode == SADC_SEQUENTIAL) |=> state_r == ST_SAMPLE)
    else $error("sequential scan stalled");
  a_pause_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_PAUSE && !trig) |=> state_r == ST_PAUSE)
    else $error("pause left without trigger");
  a_wrap_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (store && at_end) |=> chan_r == $past(start_ch))
    else $error("channel did not wrap");
  a_res8: assert property (@(posedge pclk) disable iff (!presetn)
    (store && !res10) |=> data_r[9:8] == 2'h0)
    else $error("8-bit result too wide");
  a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (tsel == SADC_TRIG_EXT && trig) |-> $past(ext_trig) && !ext_trig)
    else $error("external trigger not falling edge");

  // Timing floors, measured rather than trusted to the counter constants
  a_sample_min: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_r == ST_SAMPLE) |-> samp_run_r >= 11'(SAMPLE_CYC))
    else $error("sampling run below minimum");
  a_conv_min: assert property (@(posedge pclk) disable iff (!presetn)
    store |-> conv_run_r >= 11'(`SADC_CONV_CYC))
    else $error("conversion run below minimum");
  // Channel order and sequencing
  a_start_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && trig) |=> chan_r == $past(start_ch))
    else $error("scan did not begin at start channel");
  a_sample_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_SAMPLE) |=> $stable(chan_r))
    else $error("channel changed while sampling");
  a_chan_step: assert property (@(posedge pclk) disable iff (!presetn)
    (store && !at_end) |=> chan_r == $past(chan_r) + 3'h1)
    else $error("channel did not advance");
  a_wrap_seq: assert property (@(posedge pclk) disable iff (!presetn)
    (store && at_end && mode == SADC_SEQUENTIAL) |=> state_r == ST_SAMPLE)
    else $error("sequential scan did not restart");
  a_pause_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_PAUSE) |=> $stable(chan_r))
    else $error("channel moved during pause");
  a_pause_go: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_PAUSE && trig) |=> state_r == ST_SAMPLE)
    else $error("pause not left on trigger");
  a_conv_deaf: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_APPROX && cnt_r != 10'h000 && trig) |=> state_r == ST_APPROX)
    else $error("trigger disturbed conversion");
  // Successive approximation
  a_first_trial: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_SAMPLE && cnt_r == 10'h000) |=> code_r == 10'h200)
    else $error("first trial code wrong");
  a_trial_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_APPROX && cnt_r != 10'h000) |=> $stable(code_r))
    else $error("trial code moved inside a bit");
  // Result register and flags
  a_res10_full: assert property (@(posedge pclk) disable iff (!presetn)
    (store && res10) |=> data_r == $past(code_r))
    else $error("10-bit result wrong");
  a_ctrl_res: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `SADC_OFF_CTRL)) |=> res10 == $past(pwdata[`SADC_CTRL_RES10]))
    else $error("resolution select not written");
  a_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !store |=> $stable(data_r))
    else $error("result changed without store");
  a_store_once: assert property (@(posedge pclk) disable iff (!presetn)
    store |=> !store)
    else $error("result stored twice");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `SADC_OFF_IRQ_CLR) && pwdata[`SADC_IRQ_DONE] && !store)
    |=> !irq_stat_r[`SADC_IRQ_DONE])
    else $error("done flag not cleared");
  a_scan_flag: assert property (@(posedge pclk) disable iff (!presetn)
    scan_done |=> irq_stat_r[`SADC_IRQ_SCAN])
    else $error("scan done flag missing");
  a_xfer_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_req |=> !xfer_req)
    else $error("transfer request longer than one cycle");

  c_single: cover property (@(posedge pclk) disable iff (!presetn) scan_done);
  c_seq: cover property (@(posedge pclk) disable iff (!presetn)
    store && mode == SADC_SEQUENTIAL && at_end);
  c_pause: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_PAUSE && trig);
  c_res8: cover property (@(posedge pclk) disable iff (!presetn) store && !res10);
  c_ext_start: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE && trig && tsel == SADC_TRIG_EXT);

endmodule
`default_nettype wire

// [verification/sadc_afe_model.sv]
// Front end model: holds the selected channel level, compares it with the trial code.
// Assumes the bench supplies eight 10-bit channel levels.
`default_nettype none
module sadc_afe_model
  import sadc_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Converter side
  input wire sadc_afe_s afe,
  input wire logic [79:0] levels,
  output logic comp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_r;
  always_ff @(posedge pclk) begin
    if (afe.sample) begin
      held_r <= levels[afe.chan * 10 +: 10];
    end
  end
  // Ideal comparator, no offset or noise
  assign comp_hi = held_r >= afe.dac_code;
endmodule
`default_nettype wire

// [verification/sar_adc_scan_control_bench.sv]
// Self-checking bench of the scan converter control.
// Assumes the design, its package and the front end model are compiled first.
`include "sadc_defs.svh"
`default_nettype none
module sar_adc_scan_control_bench import sadc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic timer_trig = 0, ext_trig = 1;
  logic pready, pslverr, comp_hi, busy, irq, xfer_req, err_seen;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, ctrl;
  logic [79:0] levels;
  sadc_afe_s afe;
  int errors = 0, samples_checked = 0, cycles = 0, samp_len = 0, conv_len = 0, nres = 0;
  int s, e;
  sadc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trig(timer_trig), .ext_trig(ext_trig), .afe(afe),
    .comp_hi(comp_hi), .busy(busy), .irq(irq), .xfer_req(xfer_req));
  sadc_afe_model afe_m (.pclk(pclk), .afe(afe), .levels(levels), .comp_hi(comp_hi));
  initial forever #5 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Phase lengths; skipped in reset so an aborted sample is not judged
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    samp_len <= afe.sample ? samp_len + 1 : 0;
    conv_len <= (!busy || xfer_req) ? 0 : conv_len + 1;
    if (xfer_req) nres <= nres + 1;
    if (presetn && !afe.sample && samp_len > 0) check("sample", samp_len >= `SADC_SAMPLE_CYC, 1);
    if (xfer_req) check("conv", conv_len >= `SADC_CONV_CYC, 1);
    if (cycles == 90000) begin
      errors++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rst();
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
  endtask
  task automatic fire(input int t);
    if (t == 0) apb(1, `SADC_OFF_CTRL, ctrl | 1);
    else if (t == 1) timer_trig <= 1;
    else ext_trig <= 0;
    @(posedge pclk);
    timer_trig <= 0;
    ext_trig <= 1;
    @(posedge pclk);
  endtask
  function automatic logic [9:0] lv(input int c);
    return levels[c * 10 +: 10];
  endfunction
  task automatic run(input int m, t, r, n);
    int ch, k, w, c0;
    ch = s;
    ctrl = 32'h1_0000 | r << 1 | m << 2 | t << 4 | s << 8 | e << 12;
    apb(1, `SADC_OFF_CTRL, ctrl);
    fire(t);
    for (k = 0; k < n; k++) begin
      for (w = 0; w < 900 && xfer_req !== 1'b1; w++) @(posedge pclk);
      check("xfer", xfer_req, 1);
      @(posedge pclk);
      apb(0, `SADC_OFF_DATA, 0);
      check("data", rd, r ? lv(ch) : lv(ch) >> 2);
      c0 = nres;
      if (m == 2 && k < n - 1) begin
        repeat (700) @(posedge pclk);
        check("pause", nres - c0 + !busy, 0);
        fire(t);
      end else if (k == 0 && k < n - 1) fire(t);
      ch = ch == e ? s : (ch + 1) % 8;
    end
    c0 = nres;
    repeat (700) @(posedge pclk);
    check("end", {busy, nres != c0}, {m == 1 || m == 2, m == 1});
  endtask
  initial begin
    void'($urandom(32'h6C0C9182));
    levels = 80'({$urandom, $urandom, $urandom});
    rst();
    apb(0, `SADC_OFF_CTRL, 0);
    check("ctrl_rst", rd, `SADC_CTRL_RESET);
    apb(0, `SADC_OFF_STAT, 0);
    check("stat_rst", rd, 0);
    apb(0, 12'h018, 0);
    check("slverr", err_seen, 1);
    check("unmapped", rd, 0);
    apb(1, `SADC_OFF_CTRL, 32'h0001_773E);
    apb(0, `SADC_OFF_CTRL, 0);
    check("ctrl_rw", rd, 32'h0001_773E);
    rst();
    s = $urandom % 8;
    e = $urandom % 8;
    run(0, 0, 1, ((e - s) & 7) + 1);
    apb(0, `SADC_OFF_IRQ_STAT, 0);
    check("irq_stat", rd, 3);
    check("irq_masked", irq, 0);
    apb(1, `SADC_OFF_IRQ_EN, 1);
    check("irq_on", irq, 1);
    apb(1, `SADC_OFF_IRQ_CLR, 3);
    check("irq_clr", irq, 0);
    apb(0, `SADC_OFF_IRQ_STAT, 0);
    check("irq_stat_clr", rd, 0);
    for (int t = 0; t < 3; t++) begin
      rst();
      s = $urandom % 8;
      e = s;
      run(0, t, 0, 1);
    end
    // Sequential wraps past channel 7; its reset lands mid-sample
    for (int m = 1; m < 4; m++) begin
      rst();
      s = m == 1 ? 6 : $urandom % 8;
      e = m == 1 ? 1 : $urandom % 8;
      run(m, 0, m & 1, ((e - s) & 7) + 1 + (m == 3 ? 0 : 2));
    end
    apb(0, `SADC_OFF_IRQ_STAT, 0);
    check("irq_stat3", rd, 3);
    stop_test();
  end
endmodule
`default_nettype wire
